// ### cpt_pkg.sv
/*
 * Package for the eight-bit carrier/PWM timer: register addresses, field
 * positions, reset values, mode and clock-select codes, bus carrier struct.
 * Assumes an 8-bit on-chip bus with 16-bit addresses.
 */
package cpt_pkg;

    // ****************************************************************
    // Register addresses
    // ****************************************************************
    localparam logic [15:0] ADDR_CYCLE_COMPARE   = 16'hff1a;
    localparam logic [15:0] ADDR_DUTY_COMPARE    = 16'hff1b;
    localparam logic [15:0] ADDR_TIMER_MODE_CTRL = 16'hff6c;
    localparam logic [15:0] ADDR_CARRIER_CONTROL = 16'hff71;

    localparam logic [7:0]  REG_RESET            = 8'h00;
    localparam logic [7:0]  COUNT_ZERO           = 8'h00;
    localparam logic [7:0]  COUNT_ONE            = 8'h01;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MODE_ENABLE_BIT   = 7;
    localparam int MODE_CKS_HI       = 6;
    localparam int MODE_CKS_LO       = 4;
    localparam int MODE_MD_HI        = 3;
    localparam int MODE_MD_LO        = 2;
    localparam int MODE_LEVEL_BIT    = 1;
    localparam int MODE_OE_BIT       = 0;
    localparam int CARR_SELECT_BIT   = 2;
    localparam int CARR_REMOTE_BIT   = 1;
    localparam int CARR_STATUS_BIT   = 0;
    localparam logic [7:0] CARR_WRITE_MASK = 8'h06;

    // ****************************************************************
    // Codes
    // ****************************************************************
    localparam logic [1:0] MODE_INTERVAL = 2'h0;
    localparam logic [1:0] MODE_CARRIER  = 2'h1;
    localparam logic [1:0] MODE_PWM      = 2'h2;

    // Prescaler taps for codes 1..4 on peripheral clock, 5..6 on low-speed
    localparam int PRS_DIV_W  = 12;
    localparam int PRS_TAP_1  = 2;
    localparam int PRS_TAP_2  = 4;
    localparam int PRS_TAP_3  = 6;
    localparam int PRS_TAP_4  = 12;
    localparam int LS_DIV_W   = 9;
    localparam int LS_TAP_5   = 7;
    localparam int LS_TAP_6   = 9;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cpt_bus_t;

endpackage : cpt_pkg

// ### cpt_timer.sv
/*
 * Eight-bit timer with interval (square-wave output), PWM and carrier modes.
 * Assumes the bus strobes are single-cycle and synchronous to clk, the
 * low-speed clock arrives as a one-cycle enable tick, and the companion
 * interrupt is a synchronous level.
 */
// Behaviour
// R01: Counter equal to cycle compare raises interrupt and toggles output.
// R02: Software changes cycle compare only while disabled.
// R03: Reset clears cycle, duty, mode and carrier registers to zero.
// R04: PWM duty match toggles output without interrupt.
// R05: Carrier mode duty match raises interrupt and clears counter.
// R06: Duty writes while counting wait until match with old value.
// R07: Duty match colliding with duty write keeps old value.
// R08: Software rewrites duty compare on each restart in PWM or carrier.
// R09: Enable zero stops and clears counter; one counts on count clocks.
// R10: Clock select picks peripheral or low-speed divided count clock.
// R11: Mode field selects interval, carrier or PWM; code three prohibited.
// R12: Default output level bit sets the idle output level.
// R13: Output enable bit gates the timer output.
// R14: Software leaves mode bits unchanged while enabled.
// R15: Carrier count clock must exceed six times companion clock.
// R16: Remote and carrier-select bits gate output from companion rising edge.
// R17: Carrier status reads zero while disabled; output held low.
// R18: Carrier control bits seven to three read zero.
// R19: Carrier status is read-only, reads one while carrier output enabled.
// R20: PWM cycle match clears, interrupts, goes active, swaps compare.
// R21: Clearing enable returns interrupt and output to default levels.
// R22: Counter increments on each count clock, compared every cycle; code compares only on count clock ticks.
// R23: Level, clock-select and mode settings are held fixed while counting.
`timescale 1ns/1ps
module cpt_timer
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire cpt_pkg::cpt_bus_t bus,
    output logic [7:0]            rdata,
    input  wire logic             low_speed_tick,
    input  wire logic             companion_interrupt,
    output logic                  timer_interrupt,
    output logic                  timer_output,
    output logic                  carrier_output
);
    import cpt_pkg::*;

    logic [7:0]          cycle_compare_reg;
    logic [7:0]          duty_compare_reg;
    logic [7:0]          duty_pending_reg;
    logic                duty_pending_valid_reg;
    logic [7:0]          timer_mode_control_reg;
    logic [7:0]          carrier_control_reg;
    logic [7:0]          counter_reg;
    logic                level_reg;
    logic                compare_duty_reg;
    logic                interrupt_reg;
    logic                companion_prev_reg;
    logic                status_reg;
    logic [PRS_DIV_W-1:0] prs_div_reg;
    logic [LS_DIV_W-1:0]  ls_div_reg;
    logic                count_tick;
    logic                count_enable;
    logic [2:0]          clk_sel;
    logic [1:0]          mode;
    logic                cycle_match;
    logic                duty_match;
    logic                duty_write;
    logic                companion_rise;
    logic                carrier_pulse;

    function automatic logic is_write(input cpt_bus_t b, input logic [15:0] a);
        return b.wr && (b.addr == a);
    endfunction : is_write

    assign count_enable = timer_mode_control_reg[MODE_ENABLE_BIT];
    assign clk_sel      = timer_mode_control_reg[MODE_CKS_HI:MODE_CKS_LO];
    // R11: mode decode
    assign mode         = timer_mode_control_reg[MODE_MD_HI:MODE_MD_LO];
    assign duty_write   = is_write(bus, ADDR_DUTY_COMPARE);

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // R03: reset clears
    // R02: cycle compare writes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cycle_compare_reg <= REG_RESET;
        else if (is_write(bus, ADDR_CYCLE_COMPARE))
            cycle_compare_reg <= bus.wdata;
    end

    // R23: settings frozen
    // R14: only enable may change
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            timer_mode_control_reg <= REG_RESET;
        else if (is_write(bus, ADDR_TIMER_MODE_CTRL))
        begin
            if (count_enable)
                timer_mode_control_reg[MODE_ENABLE_BIT] <= bus.wdata[MODE_ENABLE_BIT];
            else
                timer_mode_control_reg <= bus.wdata;
        end
    end

    // R18: upper bits zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            carrier_control_reg <= REG_RESET;
        else if (is_write(bus, ADDR_CARRIER_CONTROL))
            carrier_control_reg <= bus.wdata & CARR_WRITE_MASK;
    end

    // ****************************************************************
    // Duty compare with holding latch
    // ****************************************************************
    // R06: latched while counting
    // R07: collision keeps old value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            duty_compare_reg       <= REG_RESET;
            duty_pending_reg       <= REG_RESET;
            duty_pending_valid_reg <= 1'b0;
        end
        else if (!count_enable)
        begin
            if (duty_write)
                duty_compare_reg <= bus.wdata;
            duty_pending_valid_reg <= 1'b0;
        end
        else if (duty_match)
        begin
            if (duty_pending_valid_reg && !duty_write)
                duty_compare_reg <= duty_pending_reg;
            if (!duty_write)
                duty_pending_valid_reg <= 1'b0;
        end
        else if (duty_write)
        begin
            duty_pending_reg       <= bus.wdata;
            duty_pending_valid_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // Count clock
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prs_div_reg <= '0;
        else
            prs_div_reg <= prs_div_reg + PRS_DIV_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ls_div_reg <= '0;
        else if (low_speed_tick)
            ls_div_reg <= ls_div_reg + LS_DIV_W'(1);
    end

    // R10: clock select
    always_comb
    begin
        case (clk_sel)
            3'h0:    count_tick = 1'b1;
            3'h1:    count_tick = (prs_div_reg[PRS_TAP_1-1:0] == '0);
            3'h2:    count_tick = (prs_div_reg[PRS_TAP_2-1:0] == '0);
            3'h3:    count_tick = (prs_div_reg[PRS_TAP_3-1:0] == '0);
            3'h4:    count_tick = (prs_div_reg[PRS_TAP_4-1:0] == '0);
            3'h5:    count_tick = low_speed_tick && (ls_div_reg[LS_TAP_5-1:0] == '0);
            3'h6:    count_tick = low_speed_tick && (ls_div_reg[LS_TAP_6-1:0] == '0);
            default: count_tick = low_speed_tick;
        endcase
    end

    // ****************************************************************
    // Counter and compare
    // ****************************************************************
    // R22: compare on count ticks
    assign cycle_match = count_enable && count_tick && !compare_duty_reg && (counter_reg == cycle_compare_reg);
    assign duty_match  = count_enable && count_tick && compare_duty_reg && (counter_reg == duty_compare_reg);

    // R09: stop clears counter
    // R05: carrier duty match clears
    always_ff @(posedge clk)
    begin
        if (!rst_n || !count_enable)
            counter_reg <= COUNT_ZERO;
        else if (cycle_match || (duty_match && mode == MODE_CARRIER))
            counter_reg <= COUNT_ZERO;
        else if (count_tick)
            counter_reg <= counter_reg + COUNT_ONE;
    end

    // R20: compare swap
    // R05: carrier alternates compares
    always_ff @(posedge clk)
    begin
        if (!rst_n || !count_enable || (mode != MODE_PWM && mode != MODE_CARRIER))
            compare_duty_reg <= 1'b0;
        else if (cycle_match)
            compare_duty_reg <= 1'b1;
        else if (duty_match)
            compare_duty_reg <= 1'b0;
    end

    // R01: cycle match interrupt
    // R04: no PWM duty interrupt
    // R21: stop returns defaults
    always_ff @(posedge clk)
    begin
        if (!rst_n || !count_enable)
            interrupt_reg <= 1'b0;
        else
            interrupt_reg <= cycle_match || (duty_match && mode == MODE_CARRIER);
    end

    // R01: cycle match toggles
    // R04: duty match toggles
    // R21: output back to idle
    always_ff @(posedge clk)
    begin
        if (!rst_n || !count_enable)
            level_reg <= 1'b0;
        else if (cycle_match || duty_match)
            level_reg <= !level_reg;
    end

    // R12: idle level
    // R13: output gate
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            timer_output <= 1'b0;
        else if (!timer_mode_control_reg[MODE_OE_BIT])
            timer_output <= 1'b0;
        else
            timer_output <= level_reg ^ timer_mode_control_reg[MODE_LEVEL_BIT];
    end

    assign timer_interrupt = interrupt_reg;

    // ****************************************************************
    // Carrier gating
    // ****************************************************************
    assign companion_rise = companion_interrupt && !companion_prev_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            companion_prev_reg <= 1'b0;
        else
            companion_prev_reg <= companion_interrupt;
    end

    // R16: enable at companion edge
    // R19: status follows request
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            status_reg <= 1'b0;
        else if (companion_rise)
            status_reg <= carrier_control_reg[CARR_REMOTE_BIT];
    end

    assign carrier_pulse = level_reg ^ timer_mode_control_reg[MODE_LEVEL_BIT];

    // R17: disabled holds low
    always_ff @(posedge clk)
    begin
        if (!rst_n || !status_reg)
            carrier_output <= 1'b0;
        else if (carrier_control_reg[CARR_SELECT_BIT])
            carrier_output <= carrier_pulse;
        else
            carrier_output <= 1'b1;
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // R19: status read-only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata <= REG_RESET;
        else if (bus.rd)
        begin
            case (bus.addr)
                ADDR_CYCLE_COMPARE:   rdata <= cycle_compare_reg;
                ADDR_DUTY_COMPARE:    rdata <= duty_pending_valid_reg ? duty_pending_reg : duty_compare_reg;
                ADDR_TIMER_MODE_CTRL: rdata <= timer_mode_control_reg;
                ADDR_CARRIER_CONTROL: rdata <= {carrier_control_reg[7:1], status_reg};
                default:              rdata <= REG_RESET;
            endcase
        end
    end

endmodule : cpt_timer

// ### cpt_partner.sv
/* Far-side model: low-speed count clock ticks and companion timer interrupt.
   Assumes one clk domain; comp_en lets the bench start and stop the companion. */
`timescale 1ns/1ps
module cpt_partner
#(
    parameter int LS_PER   = 2,
    parameter int COMP_PER = 40
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic comp_en,
    output logic      low_speed_tick = 1'b0,
    output logic      companion_interrupt = 1'b0
);
    int ls_cnt = 0;
    int cp_cnt = 0;
    always @(posedge clk)
    begin
        ls_cnt <= (!rst_n || ls_cnt == LS_PER - 1) ? 0 : ls_cnt + 1;
        low_speed_tick <= rst_n && ls_cnt == LS_PER - 1;
    end
    always @(posedge clk)
    begin
        cp_cnt <= (!comp_en || cp_cnt == COMP_PER - 1) ? 0 : cp_cnt + 1;
        companion_interrupt <= comp_en && cp_cnt < 2;
    end
endmodule : cpt_partner

// ### cpt_timer_chk.sv
/* Port checker for cpt_timer, bound to the timer.
   Assumes registers change only through bus writes. */
`timescale 1ns/1ps
module cpt_timer_chk
    import cpt_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire cpt_pkg::cpt_bus_t bus,
    input wire logic [7:0]        rdata,
    input wire logic              companion_interrupt,
    input wire logic              timer_interrupt,
    input wire logic              timer_output,
    input wire logic              carrier_output
);
    logic [7:0] mode_s, cyc_s, car_s;
    logic [8:0] gap_reg;
    logic [2:0] quiet_reg;
    logic       seen_reg;
    wire        en_s = mode_s[MODE_ENABLE_BIT];
    wire        wm = bus.wr && bus.addr == ADDR_TIMER_MODE_CTRL;
    wire        rem = car_s[CARR_REMOTE_BIT];
    wire        sel = car_s[CARR_SELECT_BIT];
    wire        plain = mode_s[6:4] == 3'h0 && mode_s[MODE_MD_HI:MODE_MD_LO] != MODE_CARRIER;
    always_ff @(posedge clk)
        if (!rst_n) mode_s <= REG_RESET;
        else if (wm) mode_s <= en_s ? {bus.wdata[7], mode_s[6:0]} : bus.wdata;
    always_ff @(posedge clk)
        if (!rst_n) cyc_s <= REG_RESET;
        else if (bus.wr && bus.addr == ADDR_CYCLE_COMPARE && !en_s) cyc_s <= bus.wdata;
    always_ff @(posedge clk)
        if (!rst_n) car_s <= REG_RESET;
        else if (bus.wr && bus.addr == ADDR_CARRIER_CONTROL) car_s <= bus.wdata & CARR_WRITE_MASK;
    always_ff @(posedge clk)
        if (!rst_n || !en_s) gap_reg <= 9'h0;
        else gap_reg <= timer_interrupt ? 9'h1 : gap_reg + 9'h1;
    always_ff @(posedge clk)
        if (!rst_n || !en_s) seen_reg <= 1'b0;
        else if (timer_interrupt) seen_reg <= 1'b1;
    always_ff @(posedge clk)
        if (!rst_n || wm) quiet_reg <= 3'h0;
        else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rise_off;
        $rose(companion_interrupt) && !rem ##1 !rem;
    endsequence
    sequence s_rise_on;
        $rose(companion_interrupt) && rem && !sel ##1 rem && !sel;
    endsequence
    property p_period;
        en_s && plain && seen_reg && timer_interrupt |-> gap_reg == {1'b0, cyc_s} + 9'h1;
    endproperty
    a_period: assert property (p_period) else $error("interrupt period wrong");
    property p_toggle;
        en_s && mode_s[MODE_OE_BIT] && timer_interrupt ##1 en_s |-> timer_output != $past(timer_output);
    endproperty
    a_toggle: assert property (p_toggle) else $error("output did not toggle");
    property p_pwm_quiet;
        en_s && mode_s[3:1] == 3'h4 && $fell(timer_output) |-> !$past(timer_interrupt);
    endproperty
    a_pwm_quiet: assert property (p_pwm_quiet) else $error("interrupt on duty match");
    property p_idle_off;
        !en_s [*2] |-> !timer_interrupt;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("interrupt while stopped");
    property p_idle_level;
        quiet_reg == 3'h7 && !en_s && mode_s[MODE_OE_BIT] |-> timer_output == mode_s[MODE_LEVEL_BIT];
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
    property p_carr_low;
        s_rise_off |-> ##1 !carrier_output;
    endproperty
    a_carr_low: assert property (p_carr_low) else $error("carrier output not low");
    property p_carr_high;
        s_rise_on |-> ##1 carrier_output;
    endproperty
    a_carr_high: assert property (p_carr_high) else $error("carrier output not high");
    property p_carr_rsvd;
        bus.rd && bus.addr == ADDR_CARRIER_CONTROL |=> rdata[7:3] == 5'h0;
    endproperty
    a_carr_rsvd: assert property (p_carr_rsvd) else $error("reserved bits set");
endmodule : cpt_timer_chk

bind cpt_timer cpt_timer_chk i_cpt_timer_chk (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .companion_interrupt(companion_interrupt), .timer_interrupt(timer_interrupt),
    .timer_output(timer_output), .carrier_output(carrier_output));

// ### tb.sv
/* Self-checking bench for cpt_timer with the far-side model.
   Assumes a 100 ns clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module tb;
    import cpt_pkg::*;
    localparam int LS = 2;
    localparam int CP = 40;
    logic clk = 1'b0, rst_n = 1'b0, comp_en = 1'b0;
    cpt_bus_t bus = '0;
    logic [7:0] rdata;
    logic low_speed_tick, companion_interrupt, timer_interrupt, timer_output, carrier_output;
    int errors = 0, num_checks = 0, cycles = 0;
    always #50 clk = ~clk;
    cpt_partner #(.LS_PER(LS), .COMP_PER(CP)) i_cpt_partner (.clk(clk), .rst_n(rst_n), .comp_en(comp_en),
        .low_speed_tick(low_speed_tick), .companion_interrupt(companion_interrupt));
    cpt_timer i_cpt_timer (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .low_speed_tick(low_speed_tick),
        .companion_interrupt(companion_interrupt), .timer_interrupt(timer_interrupt),
        .timer_output(timer_output), .carrier_output(carrier_output));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            stop_test();
        end
    end
    function automatic int div_of(input int c);
        int d[8] = '{1, 4, 16, 64, 4096, 128 * LS, 512 * LS, LS};
        return d[c];
    endfunction : div_of
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk({8'h00, rdata}, {8'h00, e});
    endtask : rd
    task automatic wait_irq(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (timer_interrupt !== 1'b1);
    endtask : wait_irq
    task automatic hi_width(output int n);
        n = 0;
        while (timer_output !== 1'b1) @(posedge clk);
        while (timer_output === 1'b1)
        begin
            @(posedge clk);
            n++;
        end
    endtask : hi_width
    initial
    begin
        int g, h, n, m;
        logic [15:0] regs[4] = '{ADDR_CYCLE_COMPARE, ADDR_DUTY_COMPARE, ADDR_TIMER_MODE_CTRL, ADDR_CARRIER_CONTROL};
        void'($urandom(22704));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i]) rd(regs[i], REG_RESET);
        rd(16'hff00, 8'h00);
        $display("test reset done");
        wr(ADDR_CYCLE_COMPARE, 8'h01);
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_TIMER_MODE_CTRL, 8'h00);
            wr(ADDR_TIMER_MODE_CTRL, {1'b1, c[2:0], MODE_INTERVAL, 2'b01});
            wait_irq(g);
            wait_irq(g);
            chk(16'(g), 16'(div_of(c) * 2));
        end
        wr(ADDR_TIMER_MODE_CTRL, 8'h81);
        rd(ADDR_TIMER_MODE_CTRL, 8'hf1);
        wr(ADDR_TIMER_MODE_CTRL, 8'h71);
        wr(ADDR_TIMER_MODE_CTRL, 8'h03);
        repeat (4) @(posedge clk);
        chk({15'h0, timer_output}, 16'h1);
        $display("test clock select done");
        n = 4 + $urandom % 40;
        m = $urandom % (n - 2);
        wr(ADDR_TIMER_MODE_CTRL, 8'h00);
        wr(ADDR_CYCLE_COMPARE, 8'(n));
        wr(ADDR_DUTY_COMPARE, 8'(m));
        wr(ADDR_TIMER_MODE_CTRL, 8'h89);
        wait_irq(g);
        wait_irq(g);
        chk(16'(g), 16'(n + 1));
        hi_width(h);
        chk(16'(h), 16'(m + 1));
        wr(ADDR_DUTY_COMPARE, 8'(m + 1));
        rd(ADDR_DUTY_COMPARE, 8'(m + 1));
        repeat (3) wait_irq(g);
        hi_width(h);
        chk(16'(h), 16'(m + 2));
        repeat (n - 3) @(posedge clk);
        wr(ADDR_DUTY_COMPARE, 8'(m));
        rd(ADDR_DUTY_COMPARE, 8'(m + 1));
        repeat (2) wait_irq(g);
        hi_width(h);
        chk(16'(h), 16'(m + 2));
        $display("test pwm done");
        wr(ADDR_TIMER_MODE_CTRL, 8'h00);
        wr(ADDR_CYCLE_COMPARE, 8'h04);
        wr(ADDR_DUTY_COMPARE, 8'h02);
        wr(ADDR_CARRIER_CONTROL, 8'h02);
        wr(ADDR_TIMER_MODE_CTRL, 8'h85);
        comp_en <= 1'b1;
        wait_irq(g);
        wait_irq(g);
        wait_irq(h);
        chk(16'(g + h), 16'd8);
        repeat (CP + 4) @(posedge clk);
        rd(ADDR_CARRIER_CONTROL, 8'h03);
        chk({15'h0, carrier_output}, 16'h1);
        comp_en <= 1'b0;
        wr(ADDR_TIMER_MODE_CTRL, 8'h00);
        wr(ADDR_CARRIER_CONTROL, 8'h06);
        wr(ADDR_DUTY_COMPARE, 8'h02);
        wr(ADDR_TIMER_MODE_CTRL, 8'h85);
        comp_en <= 1'b1;
        repeat (CP + 4) @(posedge clk);
        n = 0;
        repeat (40)
        begin
            @(posedge clk);
            n += (carrier_output !== h[0]);
            h = carrier_output;
        end
        chk(16'(n > 4), 16'h1);
        rd(ADDR_CARRIER_CONTROL, 8'h07);
        wr(ADDR_CARRIER_CONTROL, 8'h04);
        repeat (CP + 4) @(posedge clk);
        rd(ADDR_CARRIER_CONTROL, 8'h04);
        chk({15'h0, carrier_output}, 16'h0);
        comp_en <= 1'b0;
        wr(ADDR_TIMER_MODE_CTRL, 8'h00);
        wr(ADDR_CARRIER_CONTROL, 8'hff);
        rd(ADDR_CARRIER_CONTROL, 8'h06);
        wr(ADDR_TIMER_MODE_CTRL, 8'h02);
        repeat (3) @(posedge clk);
        chk({15'h0, timer_output}, 16'h0);
        $display("test carrier done");
        stop_test();
    end
endmodule : tb
